// ---- core/pca_map.svh ----
`ifndef PCA_MAP_SVH
`define PCA_MAP_SVH

`define NUM_MODULES 4
`define CNT_W 16
`define MODE_W 7

// register byte offsets
`define OFS_CONTROL 8'h00
`define OFS_STATUS 8'h04
`define OFS_MASK 8'h08
`define OFS_COUNTER 8'h0c
`define OFS_MODE_BASE 8'h10
`define OFS_CMP_BASE 8'h20
`define OFS_EXT_BASE 8'h30

// control register
`define CTRL_RUN_BIT 0

// module_mode_reg fields
`define MODE_IRQ_EN 0
`define MODE_PWM 1
`define MODE_TOGGLE 2
`define MODE_MATCH 3
`define MODE_FALL 4
`define MODE_RISE 5
`define MODE_COMP 6

// pwm_extension_reg fields
`define EXT_ACTIVE_BIT 0
`define EXT_RELOAD_BIT 1

// reset values
`define RST_MODE 7'h00
`define RST_BYTE 8'h00
`define RST_COUNT 16'h0000
`define RST_FLAGS 4'h0
`define RST_MASK 4'hf

`define CL_MAX 8'hff

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ---- core/pca_pkg.sv ----
`include "pca_map.svh"

package pca_pkg;

  typedef enum logic [2:0] {
    fn_idle,
    fn_capture,
    fn_timer,
    fn_toggle,
    fn_pwm
  } module_fn_t;

  typedef logic [`MODE_W-1:0] mode_bits_t;

  function automatic module_fn_t mode_of(input mode_bits_t m);
    logic cap_any;
    logic cmp_only;
    cap_any = m[`MODE_RISE] | m[`MODE_FALL];
    cmp_only = m[`MODE_COMP] & m[`MODE_MATCH] & ~cap_any & ~m[`MODE_PWM];
    if (m[`MODE_PWM] && m[`MODE_COMP] && !cap_any && !m[`MODE_MATCH] &&
        !m[`MODE_TOGGLE] && !m[`MODE_IRQ_EN]) begin
      mode_of = fn_pwm;
    end else if (cap_any && !m[`MODE_MATCH] && !m[`MODE_TOGGLE] &&
                 !m[`MODE_PWM]) begin
      mode_of = fn_capture;
    end else if (cmp_only && m[`MODE_TOGGLE]) begin
      mode_of = fn_toggle;
    end else if (cmp_only) begin
      mode_of = fn_timer;
    end else begin
      mode_of = fn_idle;
    end
  endfunction : mode_of

endpackage : pca_pkg

// ---- core/pin_edge_detect.sv ----
`timescale 1ns/1ps

module pin_edge_detect (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  input wire logic pin_in,
  output logic rise_out,
  output logic fall_out
);
  logic sync_a;
  logic sync_b;
  logic prev;

  // only sync_b looks at sync_a; edges compare sync_b with its last value
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev <= 1'b0;
      rise_out <= 1'b0;
      fall_out <= 1'b0;
    end else if (ce_in) begin
      sync_a <= pin_in;
      sync_b <= sync_a;
      prev <= sync_b;
      rise_out <= sync_b & ~prev;
      fall_out <= ~sync_b & prev;
    end
  end
endmodule : pin_edge_detect

// ---- core/capture_compare_array.sv ----
// Notes on behaviour
// - rise capture only: latch whole counter on each rising pin edge.
// - fall capture only: latch whole counter on each falling pin edge.
// - both capture bits: latch counter on every pin transition.
// - capture copies counter high and low into compare high and low.
// - capture mode interrupts only while event flag and irq enable are set.
// - comparator plus match enable: 16-bit timer flags event on equality.
// - timer mode interrupts only while event flag and irq enable set.
// - comparator, match and toggle set: pin inverts on each match.
// - pwm only with pwm and comparator set, all other mode bits clear.
// - all pwm outputs share one counter, hence one frequency.
// - pwm pin low while zero-extended counter low below active value.
// - when counter low wraps, active value reloads from reload pair.
// - duty is one minus reload over 256; 0x000 high, 0x100 low.
// - hardware sets event flag on match or capture; software clears.
// - shared counter advances only while counter run is set.
// - extension register: reload ninth bit 1, active ninth bit 0.
`timescale 1ns/1ps

module capture_compare_array
  import pca_pkg::*;
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  input wire logic [7:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  input wire logic [7:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  input wire logic [`NUM_MODULES-1:0] module_pin_in,
  output logic [`NUM_MODULES-1:0] module_pin_out,
  output logic [`NUM_MODULES-1:0] module_pin_oe_out,
  output logic irq_out
);
  localparam int N = `NUM_MODULES;

  logic counter_run;
  logic [`CNT_W-1:0] count;
  logic [3:0] module_event_flag;
  logic [3:0] irq_mask;
  mode_bits_t module_mode_reg [N];
  logic [7:0] compare_low [N];
  logic [7:0] compare_high [N];
  logic [N-1:0] active_ninth_bit;
  logic [N-1:0] reload_ninth_bit;

  logic aw_held;
  logic w_held;
  logic [7:0] waddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic wr_now;
  logic wr_ok;
  logic rd_take;
  logic [31:0] next_rdata;
  logic next_rok;
  logic tick;
  logic [N-1:0] rise;
  logic [N-1:0] fall;
  logic [N-1:0] capture;
  logic [N-1:0] match;
  module_fn_t fn [N];

  function automatic logic is_slot(input logic [7:0] a,
                                   input logic [7:0] base,
                                   input int idx);
    is_slot = (a == 8'(base + 8'(idx * 4)));
  endfunction : is_slot

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: write and read channels

  assign wr_now = aw_held & w_held & ~bvalid_out;
  assign rd_take = arvalid_in & arready_out;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awready_out <= 1'b1;
      wready_out <= 1'b1;
      waddr <= 8'h00;
      wdata <= 32'h0000_0000;
      wstrb <= 4'h0;
      bvalid_out <= 1'b0;
      bresp_out <= `RESP_OKAY;
    end else if (ce_in) begin
      if (awvalid_in && awready_out) begin
        aw_held <= 1'b1;
        awready_out <= 1'b0;
        waddr <= awaddr_in;
      end
      if (wvalid_in && wready_out) begin
        w_held <= 1'b1;
        wready_out <= 1'b0;
        wdata <= wdata_in;
        wstrb <= wstrb_in;
      end
      if (wr_now) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid_out <= 1'b1;
        bresp_out <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid_out && bready_in) begin
        bvalid_out <= 1'b0;
        awready_out <= 1'b1;
        wready_out <= 1'b1;
      end
    end
  end

  always_comb begin
    wr_ok = (waddr == `OFS_CONTROL) || (waddr == `OFS_STATUS) ||
            (waddr == `OFS_MASK) || (waddr == `OFS_COUNTER);
    for (int i = 0; i < N; i++) begin
      if (is_slot(waddr, `OFS_MODE_BASE, i) ||
          is_slot(waddr, `OFS_CMP_BASE, i) ||
          is_slot(waddr, `OFS_EXT_BASE, i)) begin
        wr_ok = 1'b1;
      end
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rok = 1'b1;
    unique case (araddr_in)
      `OFS_CONTROL: next_rdata[`CTRL_RUN_BIT] = counter_run;
      `OFS_STATUS: next_rdata[3:0] = module_event_flag;
      `OFS_MASK: next_rdata[3:0] = irq_mask;
      `OFS_COUNTER: next_rdata[15:0] = count;
      default: begin
        next_rok = 1'b0;
        for (int i = 0; i < N; i++) begin
          if (is_slot(araddr_in, `OFS_MODE_BASE, i)) begin
            next_rdata[6:0] = module_mode_reg[i];
            next_rok = 1'b1;
          end
          if (is_slot(araddr_in, `OFS_CMP_BASE, i)) begin
            next_rdata[15:0] = {compare_high[i], compare_low[i]};
            next_rok = 1'b1;
          end
          if (is_slot(araddr_in, `OFS_EXT_BASE, i)) begin
            next_rdata[`EXT_RELOAD_BIT] = reload_ninth_bit[i];
            next_rdata[`EXT_ACTIVE_BIT] = active_ninth_bit[i];
            next_rok = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      arready_out <= 1'b1;
      rvalid_out <= 1'b0;
      rdata_out <= 32'h0000_0000;
      rresp_out <= `RESP_OKAY;
    end else if (ce_in) begin
      if (rd_take) begin
        arready_out <= 1'b0;
        rvalid_out <= 1'b1;
        rdata_out <= next_rdata;
        rresp_out <= next_rok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid_out && rready_in) begin
        rvalid_out <= 1'b0;
        arready_out <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control, mask and mode registers

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      counter_run <= 1'b0;
      irq_mask <= `RST_MASK;
      for (int i = 0; i < N; i++) begin
        module_mode_reg[i] <= `RST_MODE;
      end
    end else if (ce_in && wr_now && wstrb[0]) begin
      if (waddr == `OFS_CONTROL) begin
        counter_run <= wdata[`CTRL_RUN_BIT];
      end
      if (waddr == `OFS_MASK) begin
        irq_mask <= wdata[3:0];
      end
      for (int i = 0; i < N; i++) begin
        if (is_slot(waddr, `OFS_MODE_BASE, i)) begin
          module_mode_reg[i] <= wdata[6:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared counter

  // counts system clocks; source selection sits outside this block
  assign tick = ce_in & counter_run;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      count <= `RST_COUNT;
    end else if (ce_in) begin
      if (wr_now && waddr == `OFS_COUNTER && wstrb[1:0] == 2'b11) begin
        count <= wdata[15:0];
      end else if (tick) begin
        count <= count + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-module decode, capture and match

  for (genvar g = 0; g < N; g++) begin : g_edge
    pin_edge_detect u_edge (
      .clk_in(clk_in),
      .arst_n_in(arst_n_in),
      .ce_in(ce_in),
      .pin_in(module_pin_in[g]),
      .rise_out(rise[g]),
      .fall_out(fall[g])
    );
  end

  always_comb begin
    for (int i = 0; i < N; i++) begin
      fn[i] = mode_of(module_mode_reg[i]);
      capture[i] = (fn[i] == fn_capture) &&
        ((rise[i] && module_mode_reg[i][`MODE_RISE]) ||
         (fall[i] && module_mode_reg[i][`MODE_FALL]));
      // a match counts once per counter value, as the counter leaves it
      match[i] = tick && (fn[i] == fn_timer || fn[i] == fn_toggle) &&
        (count == {compare_high[i], compare_low[i]});
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare registers: capture beats a software write in the same cycle

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < N; i++) begin
        compare_low[i] <= `RST_BYTE;
        compare_high[i] <= `RST_BYTE;
        active_ninth_bit[i] <= 1'b0;
        reload_ninth_bit[i] <= 1'b0;
      end
    end else if (ce_in) begin
      for (int i = 0; i < N; i++) begin
        if (wr_now && is_slot(waddr, `OFS_CMP_BASE, i)) begin
          if (wstrb[0]) begin
            compare_low[i] <= wdata[7:0];
          end
          if (wstrb[1]) begin
            compare_high[i] <= wdata[15:8];
          end
        end
        if (wr_now && wstrb[0] && is_slot(waddr, `OFS_EXT_BASE, i)) begin
          reload_ninth_bit[i] <= wdata[`EXT_RELOAD_BIT];
          active_ninth_bit[i] <= wdata[`EXT_ACTIVE_BIT];
        end
        if (capture[i]) begin
          compare_high[i] <= count[15:8];
          compare_low[i] <= count[7:0];
        end
        // reload only at the wrap; writes to compare low or the ext register still change the active value at once
        if (fn[i] == fn_pwm && tick && count[7:0] == `CL_MAX) begin
          compare_low[i] <= compare_high[i];
          active_ninth_bit[i] <= reload_ninth_bit[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event flags and interrupt

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      module_event_flag <= `RST_FLAGS;
    end else if (ce_in) begin
      for (int i = 0; i < N; i++) begin
        if (capture[i] || match[i]) begin
          module_event_flag[i] <= 1'b1;
        end else if (rd_take && araddr_in == `OFS_STATUS) begin
          module_event_flag[i] <= 1'b0;
        end else if (wr_now && wstrb[0] && waddr == `OFS_STATUS &&
                     wdata[i]) begin
          module_event_flag[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_out <= 1'b0;
    end else if (ce_in) begin
      irq_out <= 1'b0;
      for (int i = 0; i < N; i++) begin
        if (module_event_flag[i] && module_mode_reg[i][`MODE_IRQ_EN] &&
            irq_mask[i]) begin
          irq_out <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      module_pin_out <= '0;
      module_pin_oe_out <= '0;
    end else if (ce_in) begin
      for (int i = 0; i < N; i++) begin
        module_pin_oe_out[i] <= (fn[i] == fn_pwm) || (fn[i] == fn_toggle);
        if (fn[i] == fn_pwm) begin
          // every pwm module reads the same count, so periods match
          module_pin_out[i] <= !({1'b0, count[7:0]} <
            {active_ninth_bit[i], compare_low[i]});
        end else if (match[i] && fn[i] == fn_toggle) begin
          module_pin_out[i] <= ~module_pin_out[i];
        end
      end
    end
  end
endmodule : capture_compare_array

// ---- dv/cca_props.sv ----
`timescale 1ns/1ps

module cca_props (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  input wire logic awvalid_in,
  input wire logic awready_out,
  input wire logic wvalid_in,
  input wire logic wready_out,
  input wire logic [1:0] bresp_out,
  input wire logic bvalid_out,
  input wire logic bready_in,
  input wire logic arvalid_in,
  input wire logic arready_out,
  input wire logic [31:0] rdata_out,
  input wire logic rvalid_out,
  input wire logic rready_in,
  input wire logic [3:0] module_pin_out,
  input wire logic irq_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);

  ////////////////////////////////////////////////////////////////////////
  read_hold_a: assert property (
    rvalid_out && !rready_in |=> rvalid_out && $stable(rdata_out))
    else $error("read data not held");
  write_hold_a: assert property (
    bvalid_out && !bready_in |=> bvalid_out && $stable(bresp_out))
    else $error("write response not held");
  read_answer_a: assert property (
    arvalid_in && arready_out |=> rvalid_out)
    else $error("read not answered on next edge");
  write_answer_a: assert property (
    awvalid_in && awready_out && wvalid_in && wready_out |-> ##2 bvalid_out)
    else $error("write not answered two edges later");
  read_busy_a: assert property (
    rvalid_out |-> !arready_out)
    else $error("read address accepted while answer pending");
  write_busy_a: assert property (
    bvalid_out |-> !awready_out && !wready_out)
    else $error("write accepted while response pending");
  reset_quiet_a: assert property (
    $rose(arst_n_in) |-> !irq_out && !bvalid_out && !rvalid_out)
    else $error("outputs active right after reset");
  // a stalled enable must freeze pins and interrupt, not only the counter
  ce_freeze_a: assert property (
    !ce_in |=> $stable(module_pin_out) && $stable(irq_out))
    else $error("state moved while clock enable low");
endmodule : cca_props

bind capture_compare_array cca_props u_props (
  .clk_in, .arst_n_in, .ce_in, .awvalid_in, .awready_out, .wvalid_in,
  .wready_out, .bresp_out, .bvalid_out, .bready_in, .arvalid_in,
  .arready_out, .rdata_out, .rvalid_out, .rready_in, .module_pin_out,
  .irq_out
);

// ---- dv/pin_load.sv ----
`timescale 1ns/1ps

// external source per pin; a driving module wins the wire
module pin_load (
  input wire logic [3:0] drive_in,
  input wire logic [3:0] oe_in,
  input wire logic [3:0] level_in,
  output logic [3:0] wire_out
);
  assign wire_out = (oe_in & drive_in) | (~oe_in & level_in);
endmodule : pin_load

// ---- dv/capture_compare_array_tb.sv ----
`timescale 1ns/1ps

module capture_compare_array_tb;
  logic clk_in = 0, arst_n_in = 0, ce_in = 1;
  logic [7:0] awaddr_in = 0, araddr_in = 0;
  logic awvalid_in = 0, wvalid_in = 0, bready_in = 0;
  logic arvalid_in = 0, rready_in = 0;
  logic [31:0] wdata_in = 0, rdata_out, d;
  logic [3:0] wstrb_in = 4'hf, pin_in, pin_out, pin_oe, level = 0;
  logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
  logic [1:0] bresp_out, rresp_out;
  logic [1:0] b_resp, r_resp;
  logic irq_out;
  int n_errors = 0, check_count = 0;

  always #20 clk_in = ~clk_in;

  capture_compare_array i_dut (
    .clk_in, .arst_n_in, .ce_in, .awaddr_in, .awvalid_in, .awready_out,
    .wdata_in, .wstrb_in, .wvalid_in, .wready_out, .bresp_out,
    .bvalid_out, .bready_in, .araddr_in, .arvalid_in, .arready_out,
    .rdata_out, .rresp_out, .rvalid_out, .rready_in,
    .module_pin_in(pin_in), .module_pin_out(pin_out),
    .module_pin_oe_out(pin_oe), .irq_out
  );
  pin_load i_load (.drive_in(pin_out), .oe_in(pin_oe), .level_in(level),
    .wire_out(pin_in));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic pa, pw;
    pa = 1;
    pw = 1;
    awaddr_in <= a;
    wdata_in <= v;
    awvalid_in <= 1;
    wvalid_in <= 1;
    bready_in <= 1;
    while (pa || pw) begin
      @(posedge clk_in);
      if (pa && awready_out) begin
        pa = 0;
        awvalid_in <= 0;
      end
      if (pw && wready_out) begin
        pw = 0;
        wvalid_in <= 0;
      end
    end
    do @(posedge clk_in); while (!bvalid_out);
    b_resp = bresp_out;
    bready_in <= 0;
    // let an edge pass so a following call never drives bready twice at once
    @(posedge clk_in);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    araddr_in <= a;
    arvalid_in <= 1;
    rready_in <= 1;
    do @(posedge clk_in); while (!arready_out);
    arvalid_in <= 0;
    do @(posedge clk_in); while (!rvalid_out);
    v = rdata_out;
    r_resp = rresp_out;
    rready_in <= 0;
    @(posedge clk_in);
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    chk(v, exp);
  endtask : rc

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rc(8'h08, 32'hf);
    rc(8'h04, 32'h0);
    rc(8'h30, 32'h0);
    chk(r_resp, 2'b00);
    rc(8'h40, 32'h0);
    chk(r_resp, 2'b10);
    wr(8'h40, 32'hff);
    chk(b_resp, 2'b10);
  endtask : t_reset

  task automatic t_capture();
    logic [7:0] md [3] = '{8'h21, 8'h11, 8'h31};
    logic [31:0] last;
    last = 0;
    for (int i = 0; i < 3; i++) begin
      wr(8'h10, md[i]);
      wr(8'h0c, 32'h1000 + i);
      level[0] <= 1;
      repeat (8) @(posedge clk_in);
      if (md[i][5]) last = 32'h1000 + i;
      rc(8'h20, last);
      chk(irq_out, md[i][5]);
      rc(8'h04, {31'h0, md[i][5]});
      wr(8'h0c, 32'h2000 + i);
      level[0] <= 0;
      repeat (8) @(posedge clk_in);
      if (md[i][4]) last = 32'h2000 + i;
      rc(8'h20, last);
      rc(8'h04, {31'h0, md[i][4]});
    end
    // a masked flag must stay quiet
    wr(8'h08, 32'h0);
    level[0] <= 1;
    repeat (8) @(posedge clk_in);
    chk(irq_out, 1'b0);
    rc(8'h04, 32'h1);
    wr(8'h08, 32'hf);
  endtask : t_capture

  task automatic t_timer();
    wr(8'h14, 32'h49);
    wr(8'h24, 32'h0040);
    wr(8'h0c, 32'h0);
    wr(8'h00, 32'h1);
    for (int k = 0; k < 200 && irq_out !== 1'b1; k++) @(posedge clk_in);
    chk(irq_out, 1'b1);
    rc(8'h04, 32'h2);
    wr(8'h00, 32'h0);
    rd(8'h0c, d);
    repeat (10) @(posedge clk_in);
    rc(8'h0c, d);
    wr(8'h14, 32'h0);
  endtask : t_timer

  task automatic t_toggle();
    wr(8'h18, 32'h4c);
    wr(8'h28, 32'h0020);
    wr(8'h0c, 32'h0);
    chk(pin_out[2], 1'b0);
    wr(8'h00, 32'h1);
    ce_in <= 0;
    repeat (4) @(posedge clk_in);
    ce_in <= 1;
    repeat (60) @(posedge clk_in);
    chk({pin_oe[2], pin_out[2]}, 2'b11);
    wr(8'h0c, 32'h0018);
    repeat (30) @(posedge clk_in);
    chk(pin_out[2], 1'b0);
  endtask : t_toggle

  task automatic t_pwm();
    logic [8:0] rl [4] = '{9'h000, 9'h040, 9'h0c0, 9'h100};
    logic [31:0] hi [4] = '{256, 192, 64, 0};
    logic [31:0] c2, c3;
    wr(8'h18, 32'h42);
    wr(8'h1c, 32'h42);
    for (int i = 0; i < 4; i++) begin
      wr(8'h28, {16'h0, rl[i][7:0], 8'h00});
      wr(8'h2c, {16'h0, rl[i][7:0], 8'h00});
      wr(8'h38, {30'h0, rl[i][8], 1'b0});
      wr(8'h3c, {30'h0, rl[i][8], 1'b0});
      chk(b_resp, 2'b00);
      // a full period after reload lets any window see steady duty
      repeat (600) @(posedge clk_in);
      c2 = 0;
      c3 = 0;
      repeat (256) begin
        @(posedge clk_in);
        c2 += pin_out[2];
        c3 += pin_out[3];
      end
      chk(c2, hi[i]);
      chk(c3, hi[i]);
    end
    chk(pin_oe, 4'hc);
    wr(8'h1c, 32'h43);
    repeat (2) @(posedge clk_in);
    chk(pin_oe, 4'h4);
  endtask : t_pwm

  ////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks=%0d errors=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report

  initial begin
    repeat (30000) @(posedge clk_in);
    n_errors++;
    final_report();
  end

  initial begin
    repeat (2) @(posedge clk_in);
    arst_n_in <= 1;
    @(posedge clk_in);
    t_reset();
    t_capture();
    t_timer();
    t_toggle();
    t_pwm();
    final_report();
  end
endmodule : capture_compare_array_tb
